// File: verilog/te_act_pkg.sv
// Package: states, line signal codes and timing constants for the terminal activation FSM
`default_nettype none
package te_act_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned ID_TIMEOUT_US = 5_000;
  // Longest time: round down
  localparam int unsigned ID_CYCLES = (ID_TIMEOUT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned HOLD_MIN_MS = 500;
  localparam int unsigned HOLD_MAX_MS = 1_000;
  // Least time: round up (exact at this rate)
  localparam int unsigned HOLD_CYCLES = (HOLD_MIN_MS * (CLK_HZ / 1_000));
  // Timer T3 has no fixed value here; default is arbitrary (1 s)
  localparam int unsigned T3_MS = 1_000;
  localparam int unsigned T3_CYCLES = (T3_MS * (CLK_HZ / 1_000));
  // Contiguous ones that identify INFO 0
  localparam logic [5:0] INFO0_ONES = 6'h30;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [31:0] CNT_RST = 32'h0000_0000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    ST_F1_0,
    ST_F1_1,
    ST_F2,
    ST_F3,
    ST_F4,
    ST_F5,
    ST_F6,
    ST_F7,
    ST_F8
  } te_state_e;

  typedef enum logic [1:0] {
    TX_INFO0,
    TX_INFO1,
    TX_INFO3
  } tx_info_e;

endpackage : te_act_pkg
`default_nettype wire

// File: verilog/line_watch_if.sv
// Interface: line observations passed from the watcher to the state machine
`default_nettype none
interface line_watch_if;
  logic info0_det;
  logic id_timeout;

  modport src (
    output info0_det,
    output id_timeout
  );

  modport snk (
    input info0_det,
    input id_timeout
  );
endinterface : line_watch_if
`default_nettype wire

// File: verilog/line_watch.sv
// Module: INFO 0 detector and signal identification timeout
`default_nettype none
module line_watch #(
  parameter logic [31:0] ID_LIMIT = 32'(te_act_pkg::ID_CYCLES)
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic rx_bit_valid_i,
  input wire logic rx_bit_i,
  input wire logic rx_signal_i,
  input wire logic rx_info2_i,
  input wire logic rx_info4_i,
  line_watch_if.src watch
);

  logic [5:0] ones_reg;
  logic [31:0] id_cnt_reg;
  logic unknown;

  // ==========================================================
  // Contiguous ones counter
  // ==========================================================
  // Saturates so INFO 0 stays detected while ones keep coming
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ones_reg <= 6'h00;
    end
    else if (rx_bit_valid_i)
    begin
      if (!rx_bit_i)
      begin
        ones_reg <= 6'h00;
      end
      else if (ones_reg != te_act_pkg::INFO0_ONES)
      begin
        ones_reg <= ones_reg + 6'h01;
      end
    end
  end

  assign watch.info0_det = (ones_reg == te_act_pkg::INFO0_ONES);

  // ==========================================================
  // Identification timeout
  // ==========================================================
  assign unknown = rx_signal_i && !rx_info2_i && !rx_info4_i;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      id_cnt_reg <= te_act_pkg::CNT_RST;
    end
    else if (!unknown)
    begin
      id_cnt_reg <= te_act_pkg::CNT_RST;
    end
    else if (id_cnt_reg != ID_LIMIT)
    begin
      id_cnt_reg <= id_cnt_reg + 32'h0000_0001;
    end
  end

  assign watch.id_timeout = unknown && (id_cnt_reg == ID_LIMIT);

endmodule : line_watch
`default_nettype wire

// File: verilog/te_layer1_activation_fsm.sv
// Module: activation/deactivation state machine of a locally powered terminal
// How it works
// - nine states; INFO 1 F4, INFO 3 F6/F7
// - local power loss forces F1.0 with indications
// - local power in F1.0 gives F1.1
// - power S presence and loss move states
// - activate request in F3 starts T3, F4
// - INFO 0 after 48 ones; T3 expiry
// - unidentified signal in F4 gives F5
// - no identification within 5 ms gives F5
// - INFO 2 and lost framing transitions
// - INFO 4 activates, stops T3, enters F7
// - F1.1 reaction depends on status mode
// - optional hold timer defers PH-DI
// - INFO 0 sent promptly after INFO 0 seen
// - unsynchronisable pattern must reach F5
`default_nettype none
module te_layer1_activation_fsm #(
  parameter logic [31:0] T3_CYCLES = 32'(te_act_pkg::T3_CYCLES),
  parameter logic [31:0] HOLD_CYCLES = 32'(te_act_pkg::HOLD_CYCLES),
  parameter logic [31:0] ID_CYCLES = 32'(te_act_pkg::ID_CYCLES)
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic local_power_i,
  input wire logic power_s_i,
  input wire logic rx_bit_valid_i,
  input wire logic rx_bit_i,
  input wire logic rx_signal_i,
  input wire logic rx_info2_i,
  input wire logic rx_info4_i,
  input wire logic lost_framing_i,
  input wire logic ph_act_req_i,
  input wire logic status_by_power_i,
  input wire logic hold_en_i,
  output logic [1:0] tx_info_o,
  output logic [3:0] state_o,
  output logic ph_ai_o,
  output logic ph_di_o,
  output logic mph_ai_o,
  output logic mph_di_o,
  output logic mph_ii_c_o,
  output logic mph_ii_d_o,
  output logic mph_ei1_o,
  output logic mph_ei2_o
);

  te_act_pkg::te_state_e state_reg;
  te_act_pkg::te_state_e state_next;
  te_act_pkg::tx_info_e tx_info_reg;
  te_act_pkg::tx_info_e tx_info_next;
  logic ii_c;
  logic ii_d;
  logic ai;
  logic di;
  logic ei1;
  logic ei2;
  logic t3_start;
  logic t3_stop;
  logic hold_start;
  logic t3_run_reg;
  logic [31:0] t3_cnt_reg;
  logic t3_exp;
  logic hold_pend_reg;
  logic [31:0] hold_cnt_reg;
  logic hold_done;
  logic ph_di_next;
  logic ge3;
  logic ge4;
  logic req_blocked;
  logic rx_unknown;

  line_watch_if watch ();

  line_watch #(
    .ID_LIMIT(ID_CYCLES)
  ) u_watch (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .rx_bit_valid_i(rx_bit_valid_i),
    .rx_bit_i(rx_bit_i),
    .rx_signal_i(rx_signal_i),
    .rx_info2_i(rx_info2_i),
    .rx_info4_i(rx_info4_i),
    .watch(watch)
  );

  // ==========================================================
  // Event qualification
  // ==========================================================
  assign ge3 = (state_reg != te_act_pkg::ST_F1_0) && (state_reg != te_act_pkg::ST_F1_1)
               && (state_reg != te_act_pkg::ST_F2);
  assign ge4 = ge3 && (state_reg != te_act_pkg::ST_F3);
  // A broken receiver must not let us overlay INFO 1 on others' INFO 3
  assign req_blocked = rx_signal_i && !rx_info2_i && !rx_info4_i;
  // Timeout covers patterns we can never lock to
  assign rx_unknown = req_blocked || watch.id_timeout;

  // ==========================================================
  // Transition matrix
  // ==========================================================
  always_comb
  begin
    state_next = state_reg;
    ii_c = 1'b0;
    ii_d = 1'b0;
    ai = 1'b0;
    di = 1'b0;
    ei1 = 1'b0;
    ei2 = 1'b0;
    t3_start = 1'b0;
    t3_stop = 1'b0;
    hold_start = 1'b0;
    if (state_reg != te_act_pkg::ST_F1_0 && !local_power_i)
    begin
      state_next = te_act_pkg::ST_F1_0;
      ii_d = ge3;
      di = ge4;
    end
    else if (state_reg == te_act_pkg::ST_F1_0)
    begin
      if (local_power_i)
      begin
        state_next = te_act_pkg::ST_F1_1;
      end
    end
    else if (!power_s_i && state_reg != te_act_pkg::ST_F1_1
             && state_reg != te_act_pkg::ST_F6 && state_reg != te_act_pkg::ST_F7)
    begin
      state_next = te_act_pkg::ST_F1_1;
      ii_d = ge3;
      di = (state_reg == te_act_pkg::ST_F5) || (state_reg == te_act_pkg::ST_F8);
    end
    else
    begin
      case (state_reg)
        te_act_pkg::ST_F1_1:
        begin
          if (power_s_i)
          begin
            state_next = te_act_pkg::ST_F2;
          end
          else if (!status_by_power_i && rx_info4_i)
          begin
            state_next = te_act_pkg::ST_F7;
            ii_c = 1'b1;
            ai = 1'b1;
            t3_stop = 1'b1;
          end
          else if (!status_by_power_i && rx_info2_i)
          begin
            state_next = te_act_pkg::ST_F6;
            ii_c = 1'b1;
            t3_stop = 1'b1;
          end
        end
        te_act_pkg::ST_F2:
        begin
          if (watch.info0_det)
          begin
            state_next = te_act_pkg::ST_F3;
            ii_c = 1'b1;
          end
          else if (rx_info4_i)
          begin
            state_next = te_act_pkg::ST_F7;
            ii_c = 1'b1;
            ai = 1'b1;
          end
        end
        te_act_pkg::ST_F3, te_act_pkg::ST_F4, te_act_pkg::ST_F5:
        begin
          if (rx_info4_i)
          begin
            state_next = te_act_pkg::ST_F7;
            ai = 1'b1;
            t3_stop = 1'b1;
          end
          else if (rx_info2_i)
          begin
            state_next = te_act_pkg::ST_F6;
          end
          else if (state_reg == te_act_pkg::ST_F3)
          begin
            if (ph_act_req_i && !req_blocked)
            begin
              state_next = te_act_pkg::ST_F4;
              t3_start = 1'b1;
            end
          end
          else if (t3_exp)
          begin
            state_next = te_act_pkg::ST_F3;
            di = 1'b1;
          end
          else if (state_reg == te_act_pkg::ST_F4 && rx_unknown)
          begin
            state_next = te_act_pkg::ST_F5;
          end
        end
        te_act_pkg::ST_F6, te_act_pkg::ST_F7, te_act_pkg::ST_F8:
        begin
          if (watch.info0_det)
          begin
            state_next = te_act_pkg::ST_F3;
            di = 1'b1;
            ei2 = (state_reg == te_act_pkg::ST_F8);
            hold_start = hold_en_i && (state_reg != te_act_pkg::ST_F6);
          end
          else if (rx_info4_i && state_reg != te_act_pkg::ST_F7)
          begin
            state_next = te_act_pkg::ST_F7;
            ai = 1'b1;
            ei2 = 1'b1;
            t3_stop = 1'b1;
          end
          else if (rx_info2_i && state_reg != te_act_pkg::ST_F6)
          begin
            state_next = te_act_pkg::ST_F6;
            ei1 = (state_reg == te_act_pkg::ST_F7);
            ei2 = (state_reg == te_act_pkg::ST_F8);
          end
          else if (lost_framing_i && state_reg != te_act_pkg::ST_F8)
          begin
            state_next = te_act_pkg::ST_F8;
            ei1 = 1'b1;
          end
          else if (t3_exp)
          begin
            // F6 reports expiry but holds its state
            di = 1'b1;
            if (state_reg == te_act_pkg::ST_F8)
            begin
              state_next = te_act_pkg::ST_F3;
            end
          end
        end
        default:
        begin
          state_next = te_act_pkg::ST_F1_0;
        end
      endcase
    end
  end

  // ==========================================================
  // State and transmitted INFO
  // ==========================================================
  always_comb
  begin
    case (state_next)
      te_act_pkg::ST_F4: tx_info_next = te_act_pkg::TX_INFO1;
      te_act_pkg::ST_F6, te_act_pkg::ST_F7: tx_info_next = te_act_pkg::TX_INFO3;
      default: tx_info_next = te_act_pkg::TX_INFO0;
    endcase
  end

  // INFO changes in the cycle after detection, far inside the response window
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= te_act_pkg::ST_F1_0;
      tx_info_reg <= te_act_pkg::TX_INFO0;
    end
    else
    begin
      state_reg <= state_next;
      tx_info_reg <= tx_info_next;
    end
  end

  // ==========================================================
  // Timer T3
  // ==========================================================
  assign t3_exp = t3_run_reg && (t3_cnt_reg == T3_CYCLES - 32'h0000_0001);

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      t3_run_reg <= 1'b0;
      t3_cnt_reg <= te_act_pkg::CNT_RST;
    end
    else if (t3_start)
    begin
      t3_run_reg <= 1'b1;
      t3_cnt_reg <= te_act_pkg::CNT_RST;
    end
    else if (t3_stop || t3_exp || state_next == te_act_pkg::ST_F1_0
             || state_next == te_act_pkg::ST_F1_1)
    begin
      t3_run_reg <= 1'b0;
      t3_cnt_reg <= te_act_pkg::CNT_RST;
    end
    else if (t3_run_reg)
    begin
      t3_cnt_reg <= t3_cnt_reg + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Deactivation hold timer
  // ==========================================================
  assign hold_done = hold_pend_reg && (hold_cnt_reg == HOLD_CYCLES - 32'h0000_0001);

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hold_pend_reg <= 1'b0;
      hold_cnt_reg <= te_act_pkg::CNT_RST;
    end
    else if (hold_start)
    begin
      hold_pend_reg <= 1'b1;
      hold_cnt_reg <= te_act_pkg::CNT_RST;
    end
    else if (hold_done || di || state_next == te_act_pkg::ST_F7)
    begin
      // Re-entering F7 swallows the deferred PH-DI
      hold_pend_reg <= 1'b0;
      hold_cnt_reg <= te_act_pkg::CNT_RST;
    end
    else if (hold_pend_reg)
    begin
      hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Indications
  // ==========================================================
  assign ph_di_next = (di && !hold_start) || (hold_done && state_next != te_act_pkg::ST_F7);

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ph_ai_o <= 1'b0;
      ph_di_o <= 1'b0;
      mph_ai_o <= 1'b0;
      mph_di_o <= 1'b0;
      mph_ii_c_o <= 1'b0;
      mph_ii_d_o <= 1'b0;
      mph_ei1_o <= 1'b0;
      mph_ei2_o <= 1'b0;
    end
    else
    begin
      ph_ai_o <= ai;
      ph_di_o <= ph_di_next;
      mph_ai_o <= ai;
      mph_di_o <= di;
      mph_ii_c_o <= ii_c;
      mph_ii_d_o <= ii_d;
      mph_ei1_o <= ei1;
      mph_ei2_o <= ei2;
    end
  end

  assign tx_info_o = tx_info_reg;
  assign state_o = state_reg;

endmodule : te_layer1_activation_fsm
`default_nettype wire

// File: dv/te_nt_model.sv
// Model: network termination line signals seen by the terminal
`default_nettype none
module te_nt_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] mode_i,
  output logic rx_bit_valid_o,
  output logic rx_bit_o,
  output logic rx_signal_o,
  output logic rx_info2_o,
  output logic rx_info4_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================
  // Line: 0 idle, 1 unknown, 2 INFO 2, 3 INFO 4
  // ==========================================
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_bit_valid_o <= 1'b0;
      rx_bit_o <= 1'b1;
      rx_signal_o <= 1'b0;
      rx_info2_o <= 1'b0;
      rx_info4_o <= 1'b0;
    end
    else
    begin
      rx_bit_valid_o <= 1'b1;
      // Idle is all ones; any signal carries zeros
      rx_bit_o <= (mode_i == 2'h0) ? 1'b1 : ~rx_bit_o;
      rx_signal_o <= (mode_i != 2'h0);
      rx_info2_o <= (mode_i == 2'h2);
      rx_info4_o <= (mode_i == 2'h3);
    end
  end
endmodule : te_nt_model
`default_nettype wire

// File: dv/te_act_checker.sv
// Checker: port-level properties of the terminal activation FSM
`default_nettype none
module te_act_checker #(
  parameter logic [31:0] T3_CYCLES = 32'h0000_0032,
  parameter logic [31:0] HOLD_CYCLES = 32'h0000_0028,
  parameter logic [31:0] ID_CYCLES = 32'h0000_001E
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic local_power_i,
  input wire logic rx_signal_i,
  input wire logic rx_info2_i,
  input wire logic rx_info4_i,
  input wire logic ph_act_req_i,
  input wire logic [1:0] tx_info_o,
  input wire logic [3:0] state_o,
  input wire logic ph_ai_o,
  input wire logic ph_di_o,
  input wire logic mph_ai_o,
  input wire logic mph_di_o,
  input wire logic mph_ii_c_o,
  input wire logic mph_ii_d_o,
  input wire logic mph_ei1_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ==========================================
  // Properties
  // ==========================================
  property p_tx;
    tx_info_o == ((state_o == 4'h4) ? 2'h1 : (state_o inside {4'h6, 4'h7}) ? 2'h2 : 2'h0);
  endproperty
  a_tx: assert property (p_tx) else $error("line code wrong for state");
  property p_lp;
    !local_power_i |=> state_o == 4'h0;
  endproperty
  a_lp: assert property (p_lp) else $error("no return to inactive");
  property p_lpdi;
    !local_power_i && state_o >= 4'h4 |=> ph_di_o && mph_di_o && mph_ii_d_o;
  endproperty
  a_lpdi: assert property (p_lpdi) else $error("power loss indications missing");
  property p_app;
    state_o == 4'h0 && local_power_i |=> state_o == 4'h1;
  endproperty
  a_app: assert property (p_app) else $error("power apply ignored");
  property p_req;
    state_o == 4'h3 && ph_act_req_i && rx_signal_i && !rx_info2_i && !rx_info4_i
      |=> state_o != 4'h4;
  endproperty
  a_req: assert property (p_req) else $error("request taken on bad line");
  property p_ai;
    ph_ai_o |-> state_o == 4'h7 && mph_ai_o;
  endproperty
  a_ai: assert property (p_ai) else $error("activation pulse out of place");
  property p_pls;
    mph_ai_o |=> !mph_ai_o;
  endproperty
  a_pls: assert property (p_pls) else $error("indication longer than a cycle");
  property p_ei1;
    state_o == 4'h8 && $past(state_o) != 4'h8 |-> mph_ei1_o;
  endproperty
  a_ei1: assert property (p_ei1) else $error("framing loss not reported");
  property p_iic;
    state_o == 4'h3 && $past(state_o) == 4'h2 |-> mph_ii_c_o;
  endproperty
  a_iic: assert property (p_iic) else $error("connect indication missing");
  property p_di;
    state_o == 4'h3 && $past(state_o) inside {4'h6, 4'h7} |-> mph_di_o;
  endproperty
  a_di: assert property (p_di) else $error("deactivation not reported");
endmodule : te_act_checker

bind te_layer1_activation_fsm te_act_checker #(
  .T3_CYCLES(T3_CYCLES), .HOLD_CYCLES(HOLD_CYCLES), .ID_CYCLES(ID_CYCLES)
) i_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .local_power_i(local_power_i),
  .rx_signal_i(rx_signal_i), .rx_info2_i(rx_info2_i), .rx_info4_i(rx_info4_i),
  .ph_act_req_i(ph_act_req_i), .tx_info_o(tx_info_o), .state_o(state_o),
  .ph_ai_o(ph_ai_o), .ph_di_o(ph_di_o), .mph_ai_o(mph_ai_o), .mph_di_o(mph_di_o),
  .mph_ii_c_o(mph_ii_c_o), .mph_ii_d_o(mph_ii_d_o), .mph_ei1_o(mph_ei1_o)
);
`default_nettype wire

// File: dv/te_layer1_activation_fsm_tb_top.sv
// Testbench: scenario tasks for the terminal activation FSM
`default_nettype none
module te_layer1_activation_fsm_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic lp = 1'b0;
  logic ps = 1'b0;
  logic lf = 1'b0;
  logic req = 1'b0;
  logic sbp = 1'b1;
  logic he = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] pl = 8'h00;
  wire bv, rb, sig, i2, i4;
  wire [1:0] tx;
  wire [3:0] st;
  wire [7:0] ind;
  int err_count = 0;
  int n_checks = 0;

  always #25 clk_i = ~clk_i;
  // Sticky pulse record: {ph_ai, ph_di, mph_ai, mph_di, ii_c, ii_d, ei1, ei2}
  always @(posedge clk_i) pl <= pl | ind;

  te_nt_model i_nt (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_i(mode),
    .rx_bit_valid_o(bv), .rx_bit_o(rb), .rx_signal_o(sig), .rx_info2_o(i2),
    .rx_info4_o(i4));

  // Short counts keep the run brief
  te_layer1_activation_fsm #(.T3_CYCLES(32'h0000_0032), .HOLD_CYCLES(32'h0000_0028),
    .ID_CYCLES(32'h0000_001E)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .local_power_i(lp), .power_s_i(ps), .rx_bit_valid_i(bv), .rx_bit_i(rb),
    .rx_signal_i(sig), .rx_info2_i(i2), .rx_info4_i(i4), .lost_framing_i(lf),
    .ph_act_req_i(req), .status_by_power_i(sbp), .hold_en_i(he),
    .tx_info_o(tx), .state_o(st), .ph_ai_o(ind[7]), .ph_di_o(ind[6]),
    .mph_ai_o(ind[5]), .mph_di_o(ind[4]), .mph_ii_c_o(ind[3]),
    .mph_ii_d_o(ind[2]), .mph_ei1_o(ind[1]), .mph_ei2_o(ind[0]));

  // ==========================================
  // Helpers
  // ==========================================
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  // Entry pulses reach the record one edge late, so wait one more negedge
  task automatic wst(input logic [3:0] s);
    int n;
    n = 0;
    while (st !== s && n < 300)
    begin
      @(negedge clk_i);
      n++;
    end
    chk({4'h0, st}, {4'h0, s});
    if (st !== s)
      conclude();
    else
      @(negedge clk_i);
  endtask : wst

  task automatic pulse_req();
    @(posedge clk_i);
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    cyc(3);
  endtask : pulse_req

  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_up();
    @(posedge clk_i);
    lp <= 1'b1;
    wst(4'h1);
    @(posedge clk_i);
    ps <= 1'b1;
    wst(4'h2);
    pl = 8'h00;
    wst(4'h3);
    chk(pl, 8'h08);
  endtask : t_up

  task automatic t_act();
    @(posedge clk_i);
    mode <= 2'h1;
    cyc(3);
    pulse_req();
    chk({4'h0, st}, 8'h03);
    @(posedge clk_i);
    mode <= 2'h0;
    cyc(2);
    pulse_req();
    wst(4'h4);
    chk({6'h00, tx}, 8'h01);
    @(posedge clk_i);
    mode <= 2'h1;
    wst(4'h5);
    pl = 8'h00;
    @(posedge clk_i);
    mode <= 2'h3;
    wst(4'h7);
    chk(pl, 8'hA0);
    chk({6'h00, tx}, 8'h02);
    pl = 8'h00;
    @(posedge clk_i);
    mode <= 2'h0;
    wst(4'h3);
    chk(pl, 8'h50);
    chk({6'h00, tx}, 8'h00);
  endtask : t_act

  task automatic t_t3();
    pulse_req();
    wst(4'h4);
    pl = 8'h00;
    wst(4'h3);
    chk(pl, 8'h50);
  endtask : t_t3

  // Hold on: PH-DI comes late, and never if F7 returns first
  task automatic t_hold();
    @(posedge clk_i);
    he <= 1'b1;
    mode <= 2'h3;
    wst(4'h7);
    pl = 8'h00;
    @(posedge clk_i);
    mode <= 2'h0;
    wst(4'h3);
    chk(pl, 8'h10);
    pl = 8'h00;
    cyc(45);
    chk(pl, 8'h40);
    @(posedge clk_i);
    mode <= 2'h3;
    wst(4'h7);
    @(posedge clk_i);
    mode <= 2'h0;
    wst(4'h3);
    pl = 8'h00;
    @(posedge clk_i);
    mode <= 2'h3;
    wst(4'h7);
    pl = 8'h00;
    cyc(45);
    chk(pl, 8'h00);
    @(posedge clk_i);
    he <= 1'b0;
    mode <= 2'h0;
    wst(4'h3);
  endtask : t_hold

  task automatic t_frame();
    @(posedge clk_i);
    mode <= 2'h2;
    wst(4'h6);
    chk({6'h00, tx}, 8'h02);
    pl = 8'h00;
    @(posedge clk_i);
    mode <= 2'h3;
    wst(4'h7);
    chk(pl, 8'hA1);
    @(posedge clk_i);
    mode <= 2'h1;
    cyc(2);
    pl = 8'h00;
    @(posedge clk_i);
    lf <= 1'b1;
    wst(4'h8);
    chk(pl, 8'h02);
    @(posedge clk_i);
    lf <= 1'b0;
    cyc(1);
    pl = 8'h00;
    @(posedge clk_i);
    ps <= 1'b0;
    wst(4'h1);
    chk(pl, 8'h54);
  endtask : t_frame

  task automatic t_f11();
    @(posedge clk_i);
    mode <= 2'h3;
    cyc(5);
    chk({4'h0, st}, 8'h01);
    pl = 8'h00;
    @(posedge clk_i);
    sbp <= 1'b0;
    wst(4'h7);
    chk(pl, 8'hA8);
    pl = 8'h00;
    @(posedge clk_i);
    lp <= 1'b0;
    wst(4'h0);
    chk(pl, 8'h54);
    chk({6'h00, tx}, 8'h00);
  endtask : t_f11

  initial
  begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk({4'h0, st}, 8'h00);
    t_up();
    t_act();
    t_t3();
    t_hold();
    t_frame();
    t_f11();
    conclude();
  end
endmodule : te_layer1_activation_fsm_tb_top
`default_nettype wire
